// file: design/scpm_pkg.sv
// constants for the strap-configured shared pin multiplexer
package scpm_pkg;
  localparam int   HD_W          = 32;
  localparam int   HD_NARROW_W   = 16;
  localparam int   GP_W          = 16;
  localparam int   GP_CLK4       = 1;
  localparam int   GP_CLK6       = 2;
  localparam int   GP_SERIAL2_EXTERNAL_CLOCK_INPUT      = 8;
  localparam int   GP_UPPER_LO   = 9;
  localparam int   GP_UPPER_N    = 7;
  localparam int   SER1_SHARED_W = 2;
  localparam int   CELL_ONLY_W   = 8;
  localparam logic STRAP_WIDTH_RST = 1'h0;
  localparam logic STRAP_CELL_RST  = 1'h0;
  localparam logic STRAP_LBUS_RST  = 1'h0;
  localparam logic GP_EN_ON      = 1'h1;
  localparam logic GP_DIR_OUT    = 1'h1;
  localparam logic OE_DRIVE      = 1'h0;
  localparam logic OE_FLOAT      = 1'h1;
endpackage

// file: design/scpm_pin_mux.sv
// shared pin multiplexer with reset straps and software gpio takeover
// Operation
// - width strap low at reset: 16-bit host port, upper data lines float
// - width strap high at reset: 32-bit host port on all data lines
// - software-selected pins change function whenever the bits change
// - strap-selected pins fix their function at reset until next reset
// - each strap-selected pin group has at most one owning peripheral; cell-only pins have none with cell strap 0
// - after reset clock outputs and serial-2 clock keep peripheral roles
// - gpio enable bit at 1 gives the pin to gpio
// - enabled gpio: direction 0 is input, 1 drives output
// - gpio lines 9 to 15 usable only with local-bus strap at 0
// - upper gpio lines inactive after reset; bus strap defaults disabled
// - default shared serial-1/cell pins carry serial-1 data and frame sync
// - cell strap 0: serial 1 owns shared pins, cell-only pins float
// - bus strap 0: host port owns shared pins, local bus disabled
module scpm_pin_mux (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        host_width_strap_pin,
  input  wire logic        cell_interface_select_strap,
  input  wire logic        local_bus_select_strap,
  input  wire logic [15:0] gpio_line_enable_bit,
  input  wire logic [15:0] gpio_line_direction_bit,
  input  wire logic [15:0] gpio_out_value,
  output logic      [15:0] gpio_in_value,
  input  wire logic        cpu_div4_clock_output,
  input  wire logic        cpu_div6_clock_output,
  output logic             clk4_pin_o,
  output logic             clk4_pin_oe_n,
  output logic             clk6_pin_o,
  output logic             clk6_pin_oe_n,
  input  wire logic        serial2_external_clock_input_pin_i,
  output logic             serial2_external_clock_input_pin_o,
  output logic             serial2_external_clock_input_pin_oe_n,
  output logic             serial2_external_clock_input,
  input  wire logic [6:0]  upper_gpio_lines_i,
  output logic      [6:0]  upper_gpio_lines_o,
  output logic      [6:0]  upper_gpio_lines_oe_n,
  input  wire logic [6:0]  lbus_upper_out,
  input  wire logic [6:0]  lbus_upper_oe_req_n,
  output logic      [6:0]  lbus_upper_in,
  input  wire logic        serial1_transmit_data,
  input  wire logic        serial1_transmit_frame_sync,
  input  wire logic [1:0]  ser1_pin_i,
  output logic      [1:0]  ser1_pin_o,
  output logic      [1:0]  ser1_pin_oe_n,
  output logic      [1:0]  cell_tx_address_in,
  input  wire logic [7:0]  cell_only_out,
  input  wire logic [7:0]  cell_only_oe_req_n,
  output logic      [7:0]  cell_only_pin_o,
  output logic      [7:0]  cell_only_pin_oe_n,
  input  wire logic [31:0] host_data_lines_i,
  output logic      [31:0] host_data_lines_o,
  output logic      [31:0] host_data_lines_oe_n,
  input  wire logic [31:0] host_port_dout,
  input  wire logic        host_port_oe_req_n,
  output logic      [31:0] host_port_din,
  input  wire logic [31:0] lbus_ad_out,
  input  wire logic        lbus_ad_oe_req_n,
  output logic      [31:0] lbus_ad_in,
  output logic             host_port_narrow_mode,
  output logic             host_port_wide_mode,
  output logic             cell_mode,
  output logic             local_bus_mode
);
  localparam int NW = scpm_pkg::HD_NARROW_W;
  localparam int UL = scpm_pkg::GP_UPPER_LO;

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  logic armed_q, armed_d, live_q;
  logic width_q, width_d, cell_q, cell_d, lb_q, lb_d;

  // armed stays set through reset so the first edge with reset low
  // takes the straps; later edges only hold them
  always_comb begin
    armed_d = 1'b0;
    width_d = width_q;
    cell_d  = cell_q;
    lb_d    = lb_q;
    if (armed_q) begin
      width_d = host_width_strap_pin;
      cell_d  = cell_interface_select_strap;
      lb_d    = local_bus_select_strap;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      armed_q <= 1'b1;
      live_q  <= 1'b0;
      width_q <= scpm_pkg::STRAP_WIDTH_RST;
      cell_q  <= scpm_pkg::STRAP_CELL_RST;
      lb_q    <= scpm_pkg::STRAP_LBUS_RST;
    end else begin
      armed_q <= armed_d;
      live_q  <= 1'b1;
      width_q <= width_d;
      cell_q  <= cell_d;
      lb_q    <= lb_d;
    end
  end

  // ------------------------------------------------------------
  // pin selection
  // ------------------------------------------------------------
  logic [15:0] en, dir, gin_d;
  logic [6:0]  up_o_d, up_oe_d, lb_in_d;
  logic [1:0]  s1_o_d, s1_oe_d, cta_d;
  logic [7:0]  co_o_d, co_oe_d;
  logic [31:0] hd_o_d, hd_oe_d, hp_in_d, lb_ad_d;
  logic        c4_o_d, c4_oe_d, c6_o_d, c6_oe_d;
  logic        cs_o_d, cs_oe_d, s2c_d;

  assign en  = gpio_line_enable_bit;
  assign dir = gpio_line_direction_bit;

  // upper lines: local bus owns them, else gpio if enabled, else idle
  generate
    for (genvar i = 0; i < scpm_pkg::GP_UPPER_N; i++) begin : g_up
      always_comb begin
        lb_in_d[i] = 1'b0;
        up_o_d[i]  = 1'b0;
        up_oe_d[i] = scpm_pkg::OE_FLOAT;
        if (lb_q) begin
          lb_in_d[i] = upper_gpio_lines_i[i];
          up_o_d[i]  = lbus_upper_out[i];
          up_oe_d[i] = lbus_upper_oe_req_n[i];
        end else if (en[UL+i] == scpm_pkg::GP_EN_ON &&
                     dir[UL+i] == scpm_pkg::GP_DIR_OUT) begin
          up_o_d[i]  = gpio_out_value[UL+i];
          up_oe_d[i] = scpm_pkg::OE_DRIVE;
        end
      end
    end
  endgenerate

  always_comb begin
    gin_d = '0;
    // clock outputs: peripheral unless gpio takes the pin
    c4_o_d  = cpu_div4_clock_output;
    c4_oe_d = scpm_pkg::OE_DRIVE;
    if (en[scpm_pkg::GP_CLK4] == scpm_pkg::GP_EN_ON) begin
      c4_o_d  = gpio_out_value[scpm_pkg::GP_CLK4];
      c4_oe_d = ~dir[scpm_pkg::GP_CLK4];
      gin_d[scpm_pkg::GP_CLK4] = clk4_pin_o;
    end
    c6_o_d  = cpu_div6_clock_output;
    c6_oe_d = scpm_pkg::OE_DRIVE;
    if (en[scpm_pkg::GP_CLK6] == scpm_pkg::GP_EN_ON) begin
      c6_o_d  = gpio_out_value[scpm_pkg::GP_CLK6];
      c6_oe_d = ~dir[scpm_pkg::GP_CLK6];
      gin_d[scpm_pkg::GP_CLK6] = clk6_pin_o;
    end
    // serial-2 clock is an input pin until gpio claims it
    s2c_d   = serial2_external_clock_input_pin_i;
    cs_o_d  = 1'b0;
    cs_oe_d = scpm_pkg::OE_FLOAT;
    if (en[scpm_pkg::GP_SERIAL2_EXTERNAL_CLOCK_INPUT] == scpm_pkg::GP_EN_ON) begin
      s2c_d   = 1'b0;
      cs_o_d  = gpio_out_value[scpm_pkg::GP_SERIAL2_EXTERNAL_CLOCK_INPUT];
      cs_oe_d = ~dir[scpm_pkg::GP_SERIAL2_EXTERNAL_CLOCK_INPUT];
      gin_d[scpm_pkg::GP_SERIAL2_EXTERNAL_CLOCK_INPUT] = serial2_external_clock_input_pin_i;
    end
    if (!lb_q) begin
      for (int k = 0; k < scpm_pkg::GP_UPPER_N; k++) begin
        if (en[UL+k] == scpm_pkg::GP_EN_ON) begin
          gin_d[UL+k] = upper_gpio_lines_i[k];
        end
      end
    end
    // serial 1 and cell interface never share ownership
    s1_o_d  = {serial1_transmit_frame_sync, serial1_transmit_data};
    s1_oe_d = {scpm_pkg::SER1_SHARED_W{scpm_pkg::OE_DRIVE}};
    cta_d   = '0;
    co_o_d  = '0;
    co_oe_d = {scpm_pkg::CELL_ONLY_W{scpm_pkg::OE_FLOAT}};
    if (cell_q) begin
      s1_o_d  = '0;
      s1_oe_d = {scpm_pkg::SER1_SHARED_W{scpm_pkg::OE_FLOAT}};
      cta_d   = ser1_pin_i;
      co_o_d  = cell_only_out;
      co_oe_d = cell_only_oe_req_n;
    end
    // host data lines: host port or local bus, narrow mode floats top half
    hp_in_d = '0;
    lb_ad_d = '0;
    hd_o_d  = host_port_dout;
    hd_oe_d = {scpm_pkg::HD_W{host_port_oe_req_n}};
    if (lb_q) begin
      lb_ad_d = host_data_lines_i;
      hd_o_d  = lbus_ad_out;
      hd_oe_d = {scpm_pkg::HD_W{lbus_ad_oe_req_n}};
    end else if (!width_q) begin
      hp_in_d[NW-1:0] = host_data_lines_i[NW-1:0];
      hd_o_d[scpm_pkg::HD_W-1:NW]  = '0;
      hd_oe_d[scpm_pkg::HD_W-1:NW] = {NW{scpm_pkg::OE_FLOAT}};
    end else begin
      hp_in_d = host_data_lines_i;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      gpio_in_value         <= '0;
      clk4_pin_o            <= 1'b0;
      clk4_pin_oe_n         <= scpm_pkg::OE_FLOAT;
      clk6_pin_o            <= 1'b0;
      clk6_pin_oe_n         <= scpm_pkg::OE_FLOAT;
      serial2_external_clock_input_pin_o           <= 1'b0;
      serial2_external_clock_input_pin_oe_n        <= scpm_pkg::OE_FLOAT;
      serial2_external_clock_input <= 1'b0;
      upper_gpio_lines_o    <= '0;
      upper_gpio_lines_oe_n <= '1;
      lbus_upper_in         <= '0;
      ser1_pin_o            <= '0;
      ser1_pin_oe_n         <= '1;
      cell_tx_address_in    <= '0;
      cell_only_pin_o       <= '0;
      cell_only_pin_oe_n    <= '1;
      host_data_lines_o     <= '0;
      host_data_lines_oe_n  <= '1;
      host_port_din         <= '0;
      lbus_ad_in            <= '0;
      host_port_narrow_mode <= 1'b0;
      host_port_wide_mode   <= 1'b0;
      cell_mode             <= 1'b0;
      local_bus_mode        <= 1'b0;
    end else begin
      gpio_in_value         <= gin_d;
      clk4_pin_o            <= c4_o_d;
      clk4_pin_oe_n         <= c4_oe_d;
      clk6_pin_o            <= c6_o_d;
      clk6_pin_oe_n         <= c6_oe_d;
      serial2_external_clock_input_pin_o           <= cs_o_d;
      serial2_external_clock_input_pin_oe_n        <= cs_oe_d;
      serial2_external_clock_input <= s2c_d;
      upper_gpio_lines_o    <= up_o_d;
      upper_gpio_lines_oe_n <= up_oe_d;
      lbus_upper_in         <= lb_in_d;
      ser1_pin_o            <= s1_o_d;
      ser1_pin_oe_n         <= s1_oe_d;
      cell_tx_address_in    <= cta_d;
      cell_only_pin_o       <= co_o_d;
      cell_only_pin_oe_n    <= co_oe_d;
      host_data_lines_o     <= hd_o_d;
      host_data_lines_oe_n  <= hd_oe_d;
      host_port_din         <= hp_in_d;
      lbus_ad_in            <= lb_ad_d;
      host_port_narrow_mode <= ~lb_q & ~width_q;
      host_port_wide_mode   <= ~lb_q & width_q;
      cell_mode             <= cell_q;
      local_bus_mode        <= lb_q;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  narrow_float_a: assert property (live_q && $past(!lb_q && !width_q) |->
    host_data_lines_oe_n[31:16] == 16'hFFFF) else $error("upper lines driven");
  wide_drive_a: assert property (live_q && $past(!lb_q && width_q &&
    !host_port_oe_req_n) |-> host_data_lines_oe_n == 32'h0)
    else $error("wide mode not driving");
  gpio_take_a: assert property (live_q && $past(en[1] && dir[1]) |->
    clk4_pin_o == $past(gpio_out_value[1]) && !clk4_pin_oe_n)
    else $error("gpio did not take clock pin");
  strap_hold_a: assert property (!armed_q |=> $stable(width_q) &&
    $stable(cell_q) && $stable(lb_q)) else $error("strap moved");
  strap_take_a: assert property (armed_q ##1 !armed_q |->
    width_q == $past(host_width_strap_pin)) else $error("strap not taken");
  cell_excl_a: assert property (live_q && $past(cell_q) |->
    ser1_pin_oe_n == 2'h3) else $error("serial 1 drives in cell mode");
  clk_default_a: assert property (live_q && $past(!en[1]) |->
    clk4_pin_o == $past(cpu_div4_clock_output)) else $error("clock lost");
  input_float_a: assert property (live_q && $past(en[2] && !dir[2]) |->
    clk6_pin_oe_n) else $error("input line drives");
  upper_idle_a: assert property (live_q && $past(!lb_q && !en[9]) |->
    upper_gpio_lines_oe_n[0]) else $error("idle upper line drives");
  upper_lbus_a: assert property (live_q && $past(lb_q) |->
    upper_gpio_lines_oe_n == $past(lbus_upper_oe_req_n))
    else $error("upper line not with local bus");
  ser1_default_a: assert property (live_q && $past(!cell_q) |->
    ser1_pin_o == $past({serial1_transmit_frame_sync, serial1_transmit_data}))
    else $error("serial 1 not on shared pins");

  narrow_seen_c: cover property (host_port_narrow_mode);
  cell_seen_c: cover property (cell_mode && !cell_only_pin_oe_n[0]);
  gpio_flip_c: cover property (!clk4_pin_oe_n ##1 en[1] ##2 clk4_pin_oe_n);
  lbus_seen_c: cover property (local_bus_mode && !upper_gpio_lines_oe_n[0]);
endmodule

// file: bench/scpm_board_model.sv
// board strap resistors and outside address-bus driver model
module scpm_board_model (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] want,
  output logic      [2:0] strap
);
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------------------------
  // strap levels
  // -------------------------------------------------------------
  // wanted level held through reset, then the outside driver lets go;
  // a pattern that changes every cycle stands for the released lines,
  // so a late capture of the straps shows up at once
  always @(posedge mclk) strap <= #1 reset ? want : ~strap;
endmodule

// file: bench/scpm_pin_mux_tb_top.sv
// self-checking bench for the shared pin multiplexer
module scpm_pin_mux_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset;
  logic [2:0] want, strap;
  logic [189:0] iv;
  logic [15:0] gpio_line_enable_bit, gpio_line_direction_bit, gpio_out_value;
  logic [15:0] gpio_in_value, ge, e_gin;
  logic cpu_div4_clock_output, cpu_div6_clock_output, serial2_external_clock_input_pin_i;
  logic clk4_pin_o, clk4_pin_oe_n, clk6_pin_o, clk6_pin_oe_n;
  logic serial2_external_clock_input_pin_o, serial2_external_clock_input_pin_oe_n, serial2_external_clock_input;
  logic [6:0] upper_gpio_lines_i, upper_gpio_lines_o, upper_gpio_lines_oe_n;
  logic [6:0] lbus_upper_out, lbus_upper_oe_req_n, lbus_upper_in;
  logic serial1_transmit_data, serial1_transmit_frame_sync;
  logic [1:0] ser1_pin_i, ser1_pin_o, ser1_pin_oe_n, cell_tx_address_in;
  logic [7:0] cell_only_out, cell_only_oe_req_n;
  logic [7:0] cell_only_pin_o, cell_only_pin_oe_n;
  logic [31:0] host_data_lines_i, host_data_lines_o, host_data_lines_oe_n;
  logic [31:0] host_port_dout, host_port_din, lbus_ad_out, lbus_ad_in;
  logic host_port_oe_req_n, lbus_ad_oe_req_n;
  logic host_port_narrow_mode, host_port_wide_mode, cell_mode;
  logic local_bus_mode, s_w, s_c, s_l, prv;
  logic [31:0] e_hoe, e_ho, e_hin, e_lai;
  logic [6:0] e_uoe, e_uo, e_lui;
  logic [2:0] e_koe, e_ko;
  logic [1:0] e_soe, e_so, e_cta;
  logic [7:0] e_coe, e_cpo;
  logic [3:0] e_md, e_mm;
  logic e_s2;
  int miscompares, check_count;
  assign {gpio_line_enable_bit, gpio_line_direction_bit, gpio_out_value,
    cpu_div4_clock_output, cpu_div6_clock_output, serial2_external_clock_input_pin_i,
    upper_gpio_lines_i, lbus_upper_out, lbus_upper_oe_req_n,
    serial1_transmit_data, serial1_transmit_frame_sync, ser1_pin_i,
    cell_only_out, cell_only_oe_req_n, host_data_lines_i, host_port_dout,
    host_port_oe_req_n, lbus_ad_out, lbus_ad_oe_req_n} = iv;
  scpm_pin_mux DUT (.*, .host_width_strap_pin(strap[2]),
    .cell_interface_select_strap(strap[1]),
    .local_bus_select_strap(strap[0]));
  scpm_board_model board (.mclk(mclk), .reset(reset), .want(want),
    .strap(strap));
  initial mclk = 1'h0;
  always #50 mclk = ~mclk;
  task complete_run();
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    check_count++;
    if ((g | m) !== (e | m)) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // -------------------------------------------------------------
  // reference model: outputs one cycle after the sampled inputs
  // -------------------------------------------------------------
  initial prv = 1'h1;
  always @(posedge mclk) begin
    ge = gpio_line_enable_bit & gpio_line_direction_bit;
    if (reset) begin
      {s_w, s_c, s_l} = 3'h0;
      {e_koe, e_ko, e_s2, e_uoe, e_uo} = {3'h7, 3'h0, 1'h0, 7'h7F, 7'h00};
      {e_hoe, e_ho, e_hin} = {32'hFFFFFFFF, 32'h0, 32'h0};
      {e_soe, e_so, e_cta, e_coe} = {2'h3, 2'h0, 2'h0, 8'hFF};
      {e_md, e_mm} = 8'h00;
      {e_gin, e_lai, e_cpo, e_lui} = '0;
    end else begin
      e_gin = {s_l ? 7'h0 : upper_gpio_lines_i & gpio_line_enable_bit[15:9],
        gpio_line_enable_bit[8] & serial2_external_clock_input_pin_i, 5'h0,
        gpio_line_enable_bit[2:1] & {e_ko[1], e_ko[2]}, 1'h0};
      e_lui = s_l ? upper_gpio_lines_i : 7'h0;
      e_lai = s_l ? host_data_lines_i : 32'h0;
      e_cpo = s_c ? cell_only_out : 8'h0;
      e_koe = {gpio_line_enable_bit[1] & ~gpio_line_direction_bit[1],
        gpio_line_enable_bit[2] & ~gpio_line_direction_bit[2], ~ge[8]};
      e_ko = {gpio_line_enable_bit[1] ? gpio_out_value[1] :
        cpu_div4_clock_output, gpio_line_enable_bit[2] ?
        gpio_out_value[2] : cpu_div6_clock_output, gpio_out_value[8]};
      e_s2 = gpio_line_enable_bit[8] ? 1'h0 : serial2_external_clock_input_pin_i;
      e_uoe = s_l ? lbus_upper_oe_req_n : ~ge[15:9];
      e_uo = s_l ? lbus_upper_out : gpio_out_value[15:9];
      e_hoe = s_l ? {32{lbus_ad_oe_req_n}} :
        {s_w ? {16{host_port_oe_req_n}} : 16'hFFFF, {16{host_port_oe_req_n}}};
      e_ho = s_l ? lbus_ad_out : host_port_dout;
      e_hin = s_l ? 32'h0 : s_w ? host_data_lines_i :
        {16'h0, host_data_lines_i[15:0]};
      e_soe = {2{s_c}};
      e_so = {serial1_transmit_frame_sync, serial1_transmit_data};
      e_cta = s_c ? ser1_pin_i : 2'h0;
      e_coe = s_c ? cell_only_oe_req_n : 8'hFF;
      e_md = {~s_l & s_w, ~s_l & ~s_w, s_c, s_l};
      e_mm = 4'h0;
      if (prv) {s_w, s_c, s_l} = strap;
    end
    prv = reset;
    #40;
    chk({clk4_pin_oe_n, clk6_pin_oe_n, serial2_external_clock_input_pin_oe_n}, e_koe, 0);
    chk({clk4_pin_o, clk6_pin_o, serial2_external_clock_input_pin_o}, e_ko, e_koe);
    chk(serial2_external_clock_input, e_s2, 0);
    chk(upper_gpio_lines_oe_n, e_uoe, 0);
    chk(upper_gpio_lines_o, e_uo, e_uoe);
    chk(host_data_lines_oe_n, e_hoe, 0);
    chk(host_data_lines_o, e_ho, e_hoe);
    chk(host_port_din, e_hin, 0);
    chk(ser1_pin_oe_n, e_soe, 0);
    chk(ser1_pin_o, e_so, e_soe);
    chk(cell_tx_address_in, e_cta, 0);
    chk(cell_only_pin_oe_n, e_coe, 0);
    chk({host_port_wide_mode, host_port_narrow_mode, cell_mode,
      local_bus_mode}, e_md, e_mm);
    chk(gpio_in_value, e_gin, 0);
    chk(lbus_upper_in, e_lui, 0);
    chk(lbus_ad_in, e_lai, 0);
    chk(cell_only_pin_o, e_cpo, 0);
  end
  // -------------------------------------------------------------
  // stimulus: every strap mix, reset again each time
  // -------------------------------------------------------------
  task stim(input bit gp);
    @(posedge mclk);
    #1;
    for (int i = 0; i < 5; i++) iv[i*32 +: 32] = $urandom;
    iv[189:160] = 30'($urandom);
    if (!gp) iv[189:174] = 16'h0;
  endtask
  initial begin
    void'($urandom(32'h5311F0DD));
    iv = '0;
    for (int k = 0; k < 8; k++) begin
      want = k[2:0];
      reset = 1'h1;
      repeat (20) @(posedge mclk);
      #1 reset = 1'h0;
      repeat (3) stim(0);
      repeat (40) stim(1);
    end
    complete_run();
  end
  // a hang costs at most four times the expected run
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
endmodule
